/* File: sirc_sir_codec.sv */
// Serial infrared pulse encoder/decoder with an AXI4-Lite control port.
// Assumes crystal and oversample inputs are far slower than i_clk.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module sirc_sir_codec import sirc_pkg::*; (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_crystal_clk,
	input wire logic i_external_oversample_clock,
	input wire logic i_uart_serial_in,
	output logic o_uart_rx_out,
	input wire logic i_optical_rx_in,
	output logic o_optical_tx_out,
	input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready
);
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [2:0] rate_select;
	logic clk_sel, fixed_pulse_select, decoder_reset_n;
	assign rate_select = ctrl_reg[CTRL_RATE_LSB +: 3];
	assign clk_sel = ctrl_reg[CTRL_CLK_SEL_BIT];
	assign fixed_pulse_select = ctrl_reg[CTRL_FIXED_BIT];
	assign decoder_reset_n = ctrl_reg[CTRL_DEC_RST_N_BIT];

	// Clock source and divider
	logic xtal_prev_reg, xtal_prev_next, ext_prev_reg, ext_prev_next;
	logic [DIV_W-1:0] div_cnt_reg, div_cnt_next, div_last;
	logic xtal_tick, ext_tick, int_tick, os_tick;

	assign xtal_tick = i_crystal_clk & ~xtal_prev_reg;
	assign ext_tick = i_external_oversample_clock & ~ext_prev_reg;
	assign div_last = sirc_div_ratio(rate_select) - 1'b1;
	// Compare with >= so a rate change never strands the counter
	assign int_tick = xtal_tick && (div_cnt_reg >= div_last);
	assign os_tick = clk_sel ? ext_tick : int_tick;

	always_comb begin
		xtal_prev_next = i_crystal_clk;
		ext_prev_next = i_external_oversample_clock;
		div_cnt_next = div_cnt_reg;
		if (int_tick) begin
			div_cnt_next = '0;
		end else if (xtal_tick) begin
			div_cnt_next = div_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			xtal_prev_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			div_cnt_reg <= '0;
		end else if (i_ce) begin
			xtal_prev_reg <= xtal_prev_next;
			ext_prev_reg <= ext_prev_next;
			div_cnt_reg <= div_cnt_next;
		end
	end

	// Transmit bit tracking and pulse requests
	sirc_fifo_if #(.W(FIFO_W)) tx_q();
	sirc_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.q(tx_q.fifo)
	);
	logic tx_prev_reg, tx_prev_next, pend_reg, pend_next;
	logic pend_fix_reg, pend_fix_next, tx_fall, bit_start;
	logic [3:0] phase_reg, phase_next;

	assign tx_fall = os_tick && tx_prev_reg && !i_uart_serial_in;
	// A held-low line starts a new low bit every sixteen oversample ticks
	assign bit_start = tx_fall || (os_tick && !tx_prev_reg &&
		!i_uart_serial_in && phase_reg == PHASE_LAST);
	assign tx_q.in_valid = pend_reg;
	assign tx_q.in_data = pend_fix_reg;

	always_comb begin
		tx_prev_next = tx_prev_reg;
		phase_next = phase_reg;
		pend_next = pend_reg && !tx_q.in_ready;
		pend_fix_next = pend_fix_reg;
		if (os_tick) begin
			tx_prev_next = i_uart_serial_in;
			phase_next = tx_fall ? 4'h0 : phase_reg + 1'b1;
		end
		// A full queue stalls the request until space opens
		if (bit_start && !pend_next) begin
			pend_next = 1'b1;
			pend_fix_next = fixed_pulse_select;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			tx_prev_reg <= 1'b1;
			phase_reg <= '0;
			pend_reg <= 1'b0;
			pend_fix_reg <= 1'b0;
		end else if (i_ce) begin
			tx_prev_reg <= tx_prev_next;
			phase_reg <= phase_next;
			pend_reg <= pend_next;
			pend_fix_reg <= pend_fix_next;
		end
	end

	// Encoder
	sirc_enc_e enc_state_reg, enc_state_next;
	logic enc_fix_reg, enc_fix_next, enc_tick, tx_out_next;
	logic [2:0] enc_cnt_reg, enc_cnt_next, enc_len;

	assign tx_q.out_ready = (enc_state_reg == ENC_IDLE) && os_tick;
	assign enc_len = enc_fix_reg ? FIXED_XTAL : PULSE_3_16;
	assign enc_tick = enc_fix_reg ? xtal_tick : os_tick;

	always_comb begin
		enc_state_next = enc_state_reg;
		enc_fix_next = enc_fix_reg;
		enc_cnt_next = enc_cnt_reg;
		case (enc_state_reg)
			ENC_IDLE: begin
				if (tx_q.out_valid && tx_q.out_ready) begin
					enc_state_next = ENC_PULSE;
					enc_fix_next = tx_q.out_data[0];
					enc_cnt_next = '0;
				end
			end
			ENC_PULSE: begin
				if (enc_tick) begin
					if (enc_cnt_reg == enc_len - 1'b1) begin
						enc_state_next = ENC_IDLE;
					end
					enc_cnt_next = enc_cnt_reg + 1'b1;
				end
			end
			default: enc_state_next = ENC_IDLE;
		endcase
		tx_out_next = (enc_state_next == ENC_PULSE);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			enc_state_reg <= ENC_IDLE;
			enc_fix_reg <= 1'b0;
			enc_cnt_reg <= '0;
			o_optical_tx_out <= 1'b0;
		end else if (i_ce) begin
			enc_state_reg <= enc_state_next;
			enc_fix_reg <= enc_fix_next;
			enc_cnt_reg <= enc_cnt_next;
			o_optical_tx_out <= tx_out_next;
		end
	end

	// Decoder: low-going optical pulse stretched to sixteen ticks
	logic rx_prev_reg, rx_prev_next, rx_out_next;
	logic [4:0] dec_cnt_reg, dec_cnt_next;

	always_comb begin
		rx_prev_next = rx_prev_reg;
		dec_cnt_next = dec_cnt_reg;
		if (!decoder_reset_n) begin
			rx_prev_next = 1'b1;
			dec_cnt_next = '0;
		end else if (os_tick) begin
			rx_prev_next = i_optical_rx_in;
			if (rx_prev_reg && !i_optical_rx_in) begin
				dec_cnt_next = RX_STRETCH;
			end else if (dec_cnt_reg != '0) begin
				dec_cnt_next = dec_cnt_reg - 1'b1;
			end
		end
		rx_out_next = (dec_cnt_next == '0);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rx_prev_reg <= 1'b1;
			dec_cnt_reg <= '0;
			o_uart_rx_out <= 1'b1;
		end else if (i_ce) begin
			rx_prev_reg <= rx_prev_next;
			dec_cnt_reg <= dec_cnt_next;
			o_uart_rx_out <= rx_out_next;
		end
	end

	// AXI4-Lite slave; address and data may arrive in either order
	logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next, status_word, rdata_next;
	logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
	logic [1:0] bresp_next, rresp_next;

	assign status_word = {27'h0, (dec_cnt_reg != '0), o_uart_rx_out,
		(enc_state_reg == ENC_PULSE), !tx_q.in_ready, !tx_q.out_valid};

	always_comb begin
		ctrl_next = ctrl_reg;
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		bvalid_next = o_s_axi_bvalid && !i_s_axi_bready;
		bresp_next = o_s_axi_bresp;
		rvalid_next = o_s_axi_rvalid && !i_s_axi_rready;
		rresp_next = o_s_axi_rresp;
		rdata_next = o_s_axi_rdata;
		if (i_s_axi_awvalid && o_s_axi_awready) begin
			aw_got_next = 1'b1;
			awaddr_next = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && o_s_axi_wready) begin
			w_got_next = 1'b1;
			wdata_next = i_s_axi_wdata;
		end
		if (aw_got_reg && w_got_reg && !o_s_axi_bvalid) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_SLVERR;
			if (awaddr_reg == REG_CTRL) begin
				bresp_next = RESP_OKAY;
				ctrl_next = wdata_reg[CTRL_W-1:0];
			end else if (awaddr_reg == REG_STATUS) begin
				bresp_next = RESP_OKAY;
			end
		end
		if (i_s_axi_arvalid && o_s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			case (i_s_axi_araddr)
				REG_CTRL: rdata_next = {26'h0, ctrl_reg};
				REG_STATUS: rdata_next = status_word;
				default: begin
					rdata_next = 32'h0;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end
		awready_next = !aw_got_next && !bvalid_next;
		wready_next = !w_got_next && !bvalid_next;
		arready_next = !rvalid_next;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl_reg <= CTRL_RESET;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= RESP_OKAY;
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rresp <= RESP_OKAY;
			o_s_axi_rdata <= 32'h0;
		end else if (i_ce) begin
			ctrl_reg <= ctrl_next;
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			o_s_axi_awready <= awready_next;
			o_s_axi_wready <= wready_next;
			o_s_axi_bvalid <= bvalid_next;
			o_s_axi_bresp <= bresp_next;
			o_s_axi_arready <= arready_next;
			o_s_axi_rvalid <= rvalid_next;
			o_s_axi_rresp <= rresp_next;
			o_s_axi_rdata <= rdata_next;
		end
	end

	// Checker helper: crystal ticks between divider ticks at a stable rate
	logic [7:0] chk_xt_reg;
	logic chk_ok_reg;
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			chk_xt_reg <= 8'h00;
			chk_ok_reg <= 1'b0;
		end else if (i_ce) begin
			if (rate_select != $past(rate_select)) begin
				chk_xt_reg <= 8'h00;
				chk_ok_reg <= 1'b0;
			end else if (int_tick) begin
				chk_xt_reg <= 8'h00;
				chk_ok_reg <= 1'b1;
			end else if (xtal_tick) begin
				chk_xt_reg <= chk_xt_reg + 8'h01;
			end
		end
	end

	sequence s_rx_fall;
		os_tick && decoder_reset_n && rx_prev_reg && !i_optical_rx_in && i_ce;
	endsequence
	sequence s_rx_low_held;
		!o_uart_rx_out [*8];
	endsequence

	a_div_ratio: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(int_tick && chk_ok_reg && $stable(rate_select)) |->
		({1'b0, chk_xt_reg} + 9'h001 == {2'b00, sirc_div_ratio(rate_select)}))
		else $error("divider period differs from rate select");
	a_src_ext: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(clk_sel && os_tick) |-> (i_external_oversample_clock && !ext_prev_reg))
		else $error("external mode ticked without external rising edge");
	a_src_int: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(!clk_sel && os_tick) |-> (i_crystal_clk && !xtal_prev_reg))
		else $error("internal mode ticked off a crystal edge");
	a_rx_stretch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		s_rx_fall |=> s_rx_low_held)
		else $error("receive output not stretched low");
	a_dec_blocked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(!decoder_reset_n && i_ce) |=> o_uart_rx_out && (dec_cnt_reg == 5'h00))
		else $error("decoder active while held in reset");
	a_tx_request: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(tx_fall && i_ce && !pend_reg) |=> pend_reg)
		else $error("transmit falling edge raised no pulse request");
	a_pulse_width: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		($fell(o_optical_tx_out) && $past(i_ce)) |->
		(enc_cnt_reg == (enc_fix_reg ? FIXED_XTAL : PULSE_3_16)))
		else $error("optical pulse ended at the wrong length");
	a_idle_dark: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(enc_state_reg == ENC_IDLE) |-> !o_optical_tx_out)
		else $error("optical output high while encoder idle");
	a_axi_bhold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(o_s_axi_bvalid && !i_s_axi_bready) |=> o_s_axi_bvalid)
		else $error("write response dropped before taken");
endmodule

/* File: sirc_pkg.sv */
// Shared constants and types of the serial infrared pulse codec.
// Assumes one 100 MHz clock; crystal and oversample pins are slow levels.
package sirc_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam int CTRL_W = 6;
	localparam int CTRL_RATE_LSB = 0;
	localparam int CTRL_CLK_SEL_BIT = 3;
	localparam int CTRL_FIXED_BIT = 4;
	localparam int CTRL_DEC_RST_N_BIT = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h20;
	localparam int ST_FIFO_EMPTY = 0;
	localparam int ST_FIFO_FULL = 1;
	localparam int ST_ENC_BUSY = 2;
	localparam int ST_RX_LEVEL = 3;
	localparam int ST_DEC_BUSY = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int DIV_W = 7;
	localparam logic [DIV_W-1:0] DIV_115200 = 7'h02;
	localparam logic [DIV_W-1:0] DIV_57600 = 7'h04;
	localparam logic [DIV_W-1:0] DIV_19200 = 7'h0C;
	localparam logic [DIV_W-1:0] DIV_9600 = 7'h18;
	localparam logic [DIV_W-1:0] DIV_38400 = 7'h06;
	localparam logic [DIV_W-1:0] DIV_4800 = 7'h30;
	localparam logic [DIV_W-1:0] DIV_2400 = 7'h60;
	localparam logic [DIV_W-1:0] DIV_TEST = 7'h01;
	localparam logic [4:0] RX_STRETCH = 5'h10;
	localparam logic [2:0] PULSE_3_16 = 3'h3;
	localparam logic [2:0] FIXED_XTAL = 3'h6;
	localparam logic [3:0] PHASE_LAST = 4'hF;
	localparam int FIFO_W = 1;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic {ENC_IDLE, ENC_PULSE} sirc_enc_e;
	function automatic logic [DIV_W-1:0] sirc_div_ratio(input logic [2:0] rs);
		case (rs)
			3'h0: sirc_div_ratio = DIV_115200;
			3'h1: sirc_div_ratio = DIV_57600;
			3'h2: sirc_div_ratio = DIV_19200;
			3'h3: sirc_div_ratio = DIV_9600;
			3'h4: sirc_div_ratio = DIV_38400;
			3'h5: sirc_div_ratio = DIV_4800;
			3'h6: sirc_div_ratio = DIV_2400;
			default: sirc_div_ratio = DIV_TEST;
		endcase
	endfunction
endpackage

/* File: sirc_fifo_if.sv */
// Valid/ready carrier between the pulse request source and its queue.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface sirc_fifo_if #(parameter int W = 1);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport fifo(input in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data);
	modport user(output in_valid, in_data, out_ready,
		input in_ready, out_valid, out_data);
endinterface

/* File: sirc_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a synchronous active-high reset and a freezing clock enable.
`timescale 1ns/1ps
module sirc_fifo #(parameter int W = 1, parameter int DEPTH = 8) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	sirc_fifo_if.fifo q
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	assign q.in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign q.out_valid = (cnt_reg != '0);
	assign q.out_data = mem[rd_reg];
	assign push = q.in_valid & q.in_ready & i_ce;
	assign pop = q.out_valid & q.out_ready & i_ce;

	always_comb begin
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (push) begin
			wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
		end
		if (pop) begin
			rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else if (i_ce) begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_reg] <= q.in_data;
		end
	end

	a_fifo_no_overrun: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cnt_reg <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
endmodule

/* File: sirc_far_model.sv */
// Far-side model: crystal, free-running 16x oscillator, infrared receiver.
// Assumes the bench sets half periods in i_clk cycles, both at least 2.
`timescale 1ns/1ps
module sirc_far_model (
	input wire logic i_clk,
	input wire logic [7:0] i_xtal_half,
	input wire logic [7:0] i_ext_half,
	input wire logic i_fire,
	input wire logic [15:0] i_fire_len,
	output logic o_xtal,
	output logic o_ext,
	output logic o_optical
);
	logic [7:0] xc = 8'h0;
	logic [7:0] ec = 8'h0;
	logic [15:0] lc = 16'h0;
	initial begin
		o_xtal = 1'h0;
		o_ext = 1'h0;
		o_optical = 1'h1;
	end
	always @(posedge i_clk) begin
		xc <= (xc + 8'h1 >= i_xtal_half) ? 8'h0 : xc + 8'h1;
		ec <= (ec + 8'h1 >= i_ext_half) ? 8'h0 : ec + 8'h1;
		if (xc + 8'h1 >= i_xtal_half) begin
			o_xtal <= !o_xtal;
		end
		if (ec + 8'h1 >= i_ext_half) begin
			o_ext <= !o_ext;
		end
		lc <= i_fire ? i_fire_len : (lc != 16'h0) ? lc - 16'h1 : 16'h0;
		// Receiver idles high; each pulse is low for the asked length
		o_optical <= !(i_fire || lc > 16'h1);
	end
endmodule

/* File: test_sir_infrared_pulse_codec.sv */
// Self-checking bench of the infrared pulse codec top.
// Assumes the far-side model makes crystal, 16x clock and optical input.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] %0t: got %0h exp %0h", $time, (a), (e)); end end
module test_sir_infrared_pulse_codec import sirc_pkg::*;;
	localparam int DV [8] = '{2, 4, 12, 24, 6, 48, 96, 1};
	logic i_clk = 1'h0;
	logic i_sys_rst = 1'h1;
	logic uart = 1'h1;
	logic [3:0] awaddr = 4'h0;
	logic awvalid = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic [3:0] araddr = 4'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic fire = 1'h0;
	logic [15:0] flen = 16'h1;
	logic [7:0] xh = 8'h2;
	logic [7:0] eh = 8'h3;
	logic xtal, ext, optical, tx, rx, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [31:0] rnd = 32'h291E;
	logic [33:0] rq[$];
	logic [31:0] mq[$];
	int tq[$];
	int xq[$];
	int errors = 0;
	int cmp_count = 0;
	int tw = 0;
	int rw = 0;
	int ew;
	int c;
	bit chk_tx = 1;

	sirc_sir_codec i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'h1),
		.i_crystal_clk(xtal), .i_external_oversample_clock(ext),
		.i_uart_serial_in(uart), .o_uart_rx_out(rx),
		.i_optical_rx_in(optical), .o_optical_tx_out(tx),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready));
	sirc_far_model i_far (.i_clk(i_clk), .i_xtal_half(xh), .i_ext_half(eh),
		.i_fire(fire), .i_fire_len(flen), .o_xtal(xtal), .o_ext(ext),
		.o_optical(optical));

	initial begin
		forever #5 i_clk = !i_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic int tp(input int code);
		tp = 2 * int'(xh) * DV[code];
	endfunction

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic hang(input string s);
		errors++;
		$display("[FAIL] %0t: no %s handshake", $time, s);
		end_sim();
	endtask

	// Sampling at the falling edge sees what the next rising edge will take
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		bit ta, tw2, tb;
		rq.push_back({r, 32'h0});
		mq.push_back(32'h0);
		@(posedge i_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 300; n++) begin
			@(negedge i_clk);
			ta = awvalid && awready;
			tw2 = wvalid && wready;
			tb = bready && bvalid;
			@(posedge i_clk);
			if (ta) awvalid <= 1'h0;
			if (tw2) wvalid <= 1'h0;
			if (tb) begin
				bready <= 1'h0;
				break;
			end
		end
		if (n == 300) hang("write");
	endtask

	task automatic axr(input logic [3:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [1:0] r);
		int n;
		bit ta, tr;
		rq.push_back({r, d});
		mq.push_back(m);
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 300; n++) begin
			@(negedge i_clk);
			ta = arvalid && arready;
			tr = rready && rvalid;
			@(posedge i_clk);
			if (ta) arvalid <= 1'h0;
			if (tr) begin
				rready <= 1'h0;
				break;
			end
		end
		if (n == 300) hang("read");
	endtask

	// One low data bit of sixteen ticks, then idle high
	task automatic tx_bit(input int t, input int w);
		tq.push_back(w);
		@(posedge i_clk);
		uart <= 1'h0;
		repeat (16 * t) @(posedge i_clk);
		uart <= 1'h1;
		repeat (t) @(posedge i_clk);
	endtask

	task automatic pulse(input int t);
		@(posedge i_clk);
		flen <= 16'(3 * t);
		fire <= 1'h1;
		@(posedge i_clk);
		fire <= 1'h0;
	endtask

	// A zero width means no received bit may appear
	task automatic rx_go(input int t, input int gap, input int w);
		if (w > 0) xq.push_back(w);
		pulse(t);
		if (gap > 0) begin
			repeat (gap - 2) @(posedge i_clk);
			pulse(t);
		end
		repeat (gap + 18 * t) @(posedge i_clk);
	endtask

	always @(negedge i_clk) begin
		if (rvalid && rready) begin
			`CHK({rresp, rdata & mq[0]}, {rq[0][33:32], rq[0][31:0] & mq[0]})
			void'(rq.pop_front());
			void'(mq.pop_front());
		end
		if (bvalid && bready) begin
			`CHK(bresp, rq[0][33:32])
			void'(rq.pop_front());
			void'(mq.pop_front());
		end
		if (tx) tw++;
		else if (tw != 0) begin
			ew = (tq.size() != 0) ? tq.pop_front() : -1;
			if (chk_tx) `CHK(tw, ew)
			tw = 0;
		end
		if (!rx) rw++;
		else if (rw != 0) begin
			ew = (xq.size() != 0) ? xq.pop_front() : -1;
			`CHK(rw, ew)
			rw = 0;
		end
	end

	initial begin
		repeat (8) @(posedge i_clk);
		i_sys_rst <= 1'h0;
		repeat (2) @(posedge i_clk);
		axr(REG_CTRL, {26'h0, CTRL_RESET}, 32'hFFFFFFFF, RESP_OKAY);
		axr(REG_STATUS, 32'h9, 32'h1F, RESP_OKAY);
		axr(4'h8, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
		axw(4'hC, 32'h3F, RESP_SLVERR);
		rnd = lfsr(rnd);
		axw(REG_CTRL, rnd, RESP_OKAY);
		axr(REG_CTRL, {26'h0, rnd[5:0]}, 32'hFFFFFFFF, RESP_OKAY);
		axw(REG_STATUS, 32'hFFFFFFFF, RESP_OKAY);
		axr(REG_STATUS, 32'h9, 32'h1F, RESP_OKAY);
		$display("test registers done");
		for (c = 0; c < 8; c++) begin
			axw(REG_CTRL, 32'h20 | c, RESP_OKAY);
			repeat (tp(c)) @(posedge i_clk);
			tx_bit(tp(c), 3 * tp(c));
			rx_go(tp(c), 0, 16 * tp(c));
		end
		axw(REG_CTRL, 32'h20, RESP_OKAY);
		rx_go(tp(0), 8 * tp(0), 24 * tp(0));
		$display("test rates done");
		axw(REG_CTRL, 32'h28, RESP_OKAY);
		repeat (6) @(posedge i_clk);
		tx_bit(6, 18);
		rx_go(6, 0, 96);
		axw(REG_CTRL, 32'h30, RESP_OKAY);
		tx_bit(tp(0), 24);
		axw(REG_CTRL, 32'h35, RESP_OKAY);
		tx_bit(tp(5), 24);
		$display("test clock modes done");
		// Fixed pulses stay on the crystal source, so the queue never fills
		chk_tx = 0;
		axw(REG_CTRL, 32'h37, RESP_OKAY);
		uart <= 1'h0;
		repeat (2000) @(posedge i_clk);
		axr(REG_STATUS, 32'h0, 32'h2, RESP_OKAY);
		uart <= 1'h1;
		repeat (4500) @(posedge i_clk);
		axr(REG_STATUS, 32'h1, 32'h3, RESP_OKAY);
		axw(REG_CTRL, 32'h20, RESP_OKAY);
		repeat (20) @(posedge i_clk);
		chk_tx = 1;
		$display("test queue done");
		axw(REG_CTRL, 32'h00, RESP_OKAY);
		rx_go(tp(0), 0, 0);
		axw(REG_CTRL, 32'h20, RESP_OKAY);
		rx_go(tp(0), 0, 16 * tp(0));
		$display("test decoder reset done");
		`CHK(tq.size() + xq.size() + rq.size(), 0)
		end_sim();
	end
endmodule
